//--- verilog/ets_sequencer.sv
// event timed step sequencer top with apb register slave
`timescale 1ns/100ps
`include "ets_consts.svh"

// What this block does
// - step timer is enabled only while start is high
// - timer advances only while the step's selected event is true
// - tick count equal to step's counts moves to the next step
// - no advancing after the last step completes or during reset
// - preset step loaded on run mode entry and while reset is high
// - sixteen steps, each with a pattern for sixteen outputs
// - each rising edge of jog advances one step
// - one tick equals timer base times ten milliseconds
// - four status words: ticks, timer, preset step, current step
// - flag of first status word shows completion, others unused
// - software may write the preset step at any time
// - a sequencer reset clears the completion flag
// - outputs are driven in run mode whatever start and reset do
// - on run mode entry outputs take the preset step pattern
// - each step event selects at most one discrete input
// - each step pattern is one sixteen bit word, bit per output
// - code zero means unassigned for events and output points
// - each output point maps to any output target independently
// - reset beats start and holds the preset step idle
// - start and reset low freeze state and outputs except on jog edges
// - after completion start and jog do nothing until reset
// - jog advance clears the timer, new step runs if started
module ets_sequencer
    import ets_pkg::*;
#(
    parameter int CENTI_CYCLES = `ETS_CENTI_CYCLES
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // sequence control inputs
    input  wire logic        START_IN,
    input  wire logic        JOG_IN,
    input  wire logic        RESET_IN,
    input  wire logic [15:0] EVENT_IN,
    // outputs
    output logic      [15:0] OUT_POINTS,
    output logic             SEQUENCE_DONE_FLAG
);

    localparam int PW = $clog2(CENTI_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CENTI_CYCLES - 1);

    // input synchronisers, filtered once stages two and three agree
    logic [18:0] raw_in;
    logic [18:0] s1_q, s2_q, s3_q, filt_q;
    logic        start_f, jog_f, reset_f, jog_prev_q, jog_rise;
    logic [15:0] event_f;

    assign raw_in = {EVENT_IN, RESET_IN, JOG_IN, START_IN};

    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else begin
            s1_q   <= raw_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
    end

    assign start_f = filt_q[0];
    assign jog_f   = filt_q[1];
    assign reset_f = filt_q[2];
    assign event_f = filt_q[18:3];

    always_ff @(posedge CLK) begin
        if (RST) begin
            jog_prev_q <= 1'b0;
        end else begin
            jog_prev_q <= jog_f;
        end
    end

    assign jog_rise = jog_f && !jog_prev_q;

    // event code 1..16 picks one input, 0 means none assigned
    function automatic logic code_sel(ets_code_t code, logic [15:0] vec);
        logic r;
        r = 1'b0;
        if ((code != 5'h00) && (code <= 5'h10)) begin
            r = vec[4'(code - 5'h01)];
        end
        return r;
    endfunction : code_sel

    // software registers
    logic        run_q, run_prev_q;
    ets_word_t   tbase_q;
    ets_code_t   last_q, preset_q;
    ets_code_t   map_q [16];
    ets_word_t   count_q, timer_q;
    ets_state_t  state_q, state_d;
    ets_code_t   cur_q, cur_d;
    logic        done_q, done_d;

    // step table
    logic [47:0] seq_row, apb_row;
    ets_word_t   step_counts, step_pattern;
    ets_code_t   step_event;
    logic        tbl_we, wr_en, acc1, pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_val;
    logic        rd_ok, is_tbl, is_map;

    assign is_tbl = (PADDR[11:8] == `ETS_TBL_REGION) && (PADDR[3:2] != 2'h3);
    assign is_map = (PADDR[11:6] == `ETS_MAP_REGION);
    assign acc1   = PSEL && PENABLE && !pready_q;
    assign wr_en  = PSEL && PENABLE && pready_q && PWRITE && rd_ok;
    assign tbl_we = wr_en && is_tbl;

    ets_step_mem #(
        .W     (16),
        .LANES (3),
        .DEPTH (16),
        .AW    (4)
    ) u_mem (
        .clk     (CLK),
        .rst     (RST),
        .we      (tbl_we),
        .waddr   (PADDR[7:4]),
        .wlane   (PADDR[3:2]),
        .wdata   (PWDATA[15:0]),
        .raddr_a (4'(cur_d - 5'h01)),
        .rdata_a (seq_row),
        .raddr_b (PADDR[7:4]),
        .rdata_b (apb_row)
    );

    assign step_counts  = seq_row[15:0];
    assign step_event   = seq_row[20:16];
    assign step_pattern = seq_row[47:32];

    // sequencing conditions
    logic event_ok, run_ok, timing, adv_time, adv_jog, adv, clr_cnt;
    logic centi, tick;
    ets_word_t eff_tbase;

    assign event_ok = (step_event == 5'h00)
                   || code_sel(step_event, event_f);
    assign run_ok   = (state_q == ETS_ACTIVE) && run_q && !reset_f
                   && start_f;
    assign timing   = run_ok && event_ok && (count_q != step_counts);
    assign adv_time = run_ok && event_ok && (count_q == step_counts);
    assign adv_jog  = (state_q == ETS_ACTIVE) && run_q && !reset_f
                   && jog_rise;
    assign adv      = adv_time || adv_jog;
    assign clr_cnt  = (state_q != ETS_ACTIVE) || !run_q || reset_f
                   || adv;
    assign eff_tbase = (tbase_q == 16'h0000) ? 16'h0001 : tbase_q;

    // ten millisecond prescaler, frozen while start or event is low, cleared on step change, reset or run exit
    logic [PW-1:0] pre_q;

    assign centi = timing && (pre_q == PRE_LAST);
    assign tick  = centi && (timer_q >= eff_tbase - 16'h0001);

    always_ff @(posedge CLK) begin
        if (RST || clr_cnt) begin
            pre_q <= '0;
        end else if (timing) begin
            pre_q <= centi ? '0 : pre_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || clr_cnt) begin
            timer_q <= 16'h0000;
        end else if (centi) begin
            timer_q <= tick ? 16'h0000 : timer_q + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || clr_cnt) begin
            count_q <= 16'h0000;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // step state machine
    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        done_d  = done_q;
        case (state_q)
            ETS_OFF: begin
                if (run_q) begin
                    state_d = ETS_ACTIVE;
                    cur_d   = preset_q;
                    done_d  = 1'b0;
                end
            end
            ETS_ACTIVE: begin
                if (!run_q) begin
                    state_d = ETS_OFF;
                end else if (reset_f) begin
                    cur_d = preset_q;
                end else if (adv) begin
                    if (cur_q == last_q) begin
                        state_d = ETS_DONE;
                        done_d  = 1'b1;
                    end else begin
                        cur_d = cur_q + 5'h01;
                    end
                end
            end
            ETS_DONE: begin
                if (!run_q) begin
                    state_d = ETS_OFF;
                end else if (reset_f) begin
                    state_d = ETS_ACTIVE;
                    cur_d   = preset_q;
                    done_d  = 1'b0;
                end
            end
            default: begin
                state_d = ETS_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ETS_OFF;
            cur_q   <= `ETS_PRESET_RST;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            done_q  <= done_d;
        end
    end

    // output point mapping; several points may share a target, they or
    logic [15:0] mapped;

    always_comb begin
        mapped = 16'h0000;
        for (int p = 0; p < 16; p++) begin
            if ((map_q[p] != 5'h00) && (map_q[p] <= 5'h10)) begin
                mapped[4'(map_q[p] - 5'h01)] |= step_pattern[p];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            OUT_POINTS         <= 16'h0000;
            SEQUENCE_DONE_FLAG <= 1'b0;
        end else begin
            OUT_POINTS <= (state_q == ETS_OFF) ? 16'h0000
                                               : mapped;
            SEQUENCE_DONE_FLAG <= done_q;
        end
    end

    // apb read decode
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (PADDR[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (PADDR == `ETS_OFF_TICKS) begin
            rd_val = {15'h0000, done_q, count_q};
        end else if (PADDR == `ETS_OFF_TIMER) begin
            rd_val = {16'h0000, timer_q};
        end else if (PADDR == `ETS_OFF_PRESET) begin
            rd_val = {27'h0000000, preset_q};
        end else if (PADDR == `ETS_OFF_CUR) begin
            rd_val = {27'h0000000, cur_q};
        end else if (PADDR == `ETS_OFF_CTRL) begin
            rd_val = {31'h00000000, run_q};
        end else if (PADDR == `ETS_OFF_TBASE) begin
            rd_val = {16'h0000, tbase_q};
        end else if (PADDR == `ETS_OFF_LAST) begin
            rd_val = {27'h0000000, last_q};
        end else if (is_map) begin
            rd_val = {27'h0000000, map_q[PADDR[5:2]]};
        end else if (is_tbl) begin
            rd_val = {16'h0000, apb_row[int'(PADDR[3:2]) * 16 +: 16]};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // one wait state so the table read port has settled
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (acc1) begin
            pready_q  <= 1'b1;
            pslverr_q <= !rd_ok;
            prdata_q  <= PWRITE ? 32'h0000_0000 : rd_val;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA  = prdata_q;

    // register writes; writes to monitor words are dropped
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_q    <= 1'b0;
            tbase_q  <= `ETS_TBASE_RST;
            last_q   <= `ETS_LAST_RST;
            preset_q <= `ETS_PRESET_RST;
            for (int p = 0; p < 16; p++) begin
                map_q[p] <= 5'h00;
            end
        end else if (wr_en) begin
            if (PADDR == `ETS_OFF_PRESET) begin
                preset_q <= PWDATA[4:0];
            end else if (PADDR == `ETS_OFF_CTRL) begin
                run_q <= PWDATA[`ETS_RUN_BIT];
            end else if (PADDR == `ETS_OFF_TBASE) begin
                tbase_q <= PWDATA[15:0];
            end else if (PADDR == `ETS_OFF_LAST) begin
                last_q <= PWDATA[4:0];
            end else if (is_map) begin
                map_q[PADDR[5:2]] <= PWDATA[4:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_q;
        end
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_start_freeze: assert property (
        (state_q == ETS_ACTIVE && run_q && !start_f && !reset_f && !jog_rise)
        |=> ($stable(count_q) && $stable(timer_q) && $stable(cur_q)))
        else $error("sequencer moved with start low");

    a_event_gate: assert property (
        (run_ok && !event_ok && !jog_rise) |=> ($stable(timer_q)
        && $stable(count_q) && $stable(cur_q)))
        else $error("timer ran with event false");

    a_step_adv: assert property (
        (adv_time && cur_q != last_q)
        |=> (cur_q == $past(cur_q) + 5'h01) && (count_q == 16'h0000))
        else $error("step did not advance on count match");

    a_done_hold: assert property (
        (state_q == ETS_DONE && run_q && !reset_f)
        |=> (state_q == ETS_DONE) && $stable(cur_q) && done_q)
        else $error("completed sequence moved without reset");

    a_reset_preset: assert property (
        (reset_f && run_q && state_q != ETS_OFF)
        |=> (cur_q == $past(preset_q)) && !done_q && (count_q == 16'h0000))
        else $error("reset did not load preset step");

    a_jog_step: assert property (
        (adv_jog && !adv_time && cur_q != last_q)
        |=> (cur_q == $past(cur_q) + 5'h01) && (timer_q == 16'h0000))
        else $error("jog did not advance one step");

    a_done_last: assert property (
        $rose(done_q) |-> (state_q == ETS_DONE) && ($past(cur_q) == last_q))
        else $error("done flag set away from last step");

    a_preset_write: assert property (
        (wr_en && PADDR == `ETS_OFF_PRESET)
        |=> (preset_q == $past(PWDATA[4:0])))
        else $error("preset write not taken");

    a_run_entry: assert property (
        (state_q == ETS_OFF && run_q) |=> (cur_q == $past(preset_q))
        ##1 (OUT_POINTS == $past(mapped)))
        else $error("run entry did not show preset pattern");

    a_timer_bound: assert property (
        timer_q < eff_tbase)
        else $error("timer passed its base");

    c_done: cover property ($rose(done_q));
    c_jog: cover property (adv_jog ##1 run_ok);
    c_reset_run: cover property (run_ok ##1 reset_f);
    c_time_adv: cover property (tick ##[1:4] adv_time);
    c_restart: cover property ($rose(run_q) && !run_prev_q ##2 run_ok);

endmodule : ets_sequencer

//--- verilog/ets_consts.svh
// constants for the event timed step sequencer: offsets, fields, resets, timing
`ifndef ETS_CONSTS_SVH
`define ETS_CONSTS_SVH

// register byte offsets
`define ETS_OFF_TICKS   12'h000
`define ETS_OFF_TIMER   12'h004
`define ETS_OFF_PRESET  12'h008
`define ETS_OFF_CUR     12'h00c
`define ETS_OFF_CTRL    12'h010
`define ETS_OFF_TBASE   12'h014
`define ETS_OFF_LAST    12'h018
// output point map at 0x040..0x07c, step table at 0x100..0x1ff
`define ETS_MAP_REGION  6'h01
`define ETS_TBL_REGION  4'h1

// field positions
`define ETS_DONE_BIT    16
`define ETS_RUN_BIT     0
`define ETS_LANE_COUNTS 2'h0
`define ETS_LANE_EVENT  2'h1
`define ETS_LANE_PATT   2'h2

// reset values
`define ETS_PRESET_RST  5'h01
`define ETS_TBASE_RST   16'h0001
`define ETS_LAST_RST    5'h10

// timing: one timer-base unit is 10 ms
`define ETS_CLK_KHZ     10000
`define ETS_UNIT_MS     10
`define ETS_CENTI_CYCLES (`ETS_UNIT_MS * `ETS_CLK_KHZ)

`endif

//--- verilog/ets_pkg.sv
// types shared by the event timed step sequencer
package ets_pkg;
    typedef logic [15:0] ets_word_t;
    typedef logic [4:0]  ets_code_t;
    typedef enum logic [1:0] {
        ETS_OFF,
        ETS_ACTIVE,
        ETS_DONE
    } ets_state_t;
endpackage : ets_pkg

//--- verilog/ets_step_mem.sv
// step table memory: per step counts, event code and output pattern
`timescale 1ns/100ps

module ets_step_mem #(
    parameter int W     = 16,
    parameter int LANES = 3,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // write port, one lane at a time
    input  wire logic               we,
    input  wire logic [AW-1:0]      waddr,
    input  wire logic [1:0]         wlane,
    input  wire logic [W-1:0]       wdata,
    // registered read ports
    input  wire logic [AW-1:0]      raddr_a,
    output logic      [W*LANES-1:0] rdata_a,
    input  wire logic [AW-1:0]      raddr_b,
    output logic      [W*LANES-1:0] rdata_b
);

    logic [W*LANES-1:0] mem_q [DEPTH];

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            if (we && (int'(wlane) < LANES)) begin
                mem_q[waddr][int'(wlane) * W +: W] <= wdata;
            end
            rdata_a <= mem_q[raddr_a];
            rdata_b <= mem_q[raddr_b];
        end
    end

endmodule : ets_step_mem

//--- verification/ets_ctl_model.sv
// controlling logic model: drives start, jog, reset and event lines
`timescale 1ns/100ps

module ets_ctl_model (
    // clock and status
    input  wire logic        clk,
    input  wire logic        done,
    // control lines
    output logic             start,
    output logic             jog,
    output logic             rst_seq,
    output logic      [15:0] evt
);
    logic        start_q = 1'b0;
    logic        rst_q   = 1'b0;
    logic        auto_q  = 1'b0;
    logic        jog_q   = 1'b0;
    logic [15:0] ev_q    = 16'h0000;

    assign start   = start_q;
    assign jog     = jog_q;
    assign evt     = ev_q;
    assign rst_seq = rst_q | (auto_q & done);

    task automatic drive(input logic s, input logic r, input logic a,
                         input logic [15:0] e);
        @(posedge clk);
        start_q <= s;
        rst_q   <= r;
        auto_q  <= a;
        ev_q    <= e;
    endtask : drive

    // held long both ways so the input filter agrees on it
    task automatic pulse_jog();
        @(posedge clk);
        jog_q <= 1'b1;
        repeat (8) @(posedge clk);
        jog_q <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse_jog
endmodule : ets_ctl_model

//--- verification/event_timed_step_sequencer_tb_top.sv
// self-checking bench for the event timed step sequencer
`timescale 1ns/100ps
`include "ets_consts.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    err_total++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end

module event_timed_step_sequencer_tb_top
    import ets_pkg::*;
;
    localparam int CC = 4;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start;
    logic        jog;
    logic        rst_seq;
    logic        done;
    logic [15:0] evt;
    logic [15:0] outp;
    logic [31:0] rd;
    logic        err;
    int          err_total = 0;
    int          checked   = 0;
    int          n;
    int          d1;
    int          d5;

    always #50 clk = ~clk;

    ets_sequencer #(.CENTI_CYCLES(CC)) DUT (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .START_IN(start),
        .JOG_IN(jog), .RESET_IN(rst_seq), .EVENT_IN(evt),
        .OUT_POINTS(outp), .SEQUENCE_DONE_FLAG(done)
    );

    ets_ctl_model ctl (
        .clk(clk), .done(done), .start(start), .jog(jog),
        .rst_seq(rst_seq), .evt(evt)
    );

    function automatic ets_word_t pat(input int k);
        return {k[7:0], k[7:0]};
    endfunction : pat

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic chk_rd(input string nm, input logic [11:0] a,
                          input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask : chk_rd

    task automatic wait_out(input ets_word_t ex, input int lim,
                            output int k);
        k = 0;
        while (outp !== ex && k < lim) begin
            @(posedge clk);
            k++;
        end
        `CHK("out_points", ex, outp)
        if (outp !== ex)
            wrap_up();
    endtask : wait_out

    task automatic t_regs();
        chk_rd("preset", `ETS_OFF_PRESET, 32'h1);
        chk_rd("tbase", `ETS_OFF_TBASE, 32'h1);
        chk_rd("ticks", `ETS_OFF_TICKS, 32'h0);
        `CHK("out_off", 16'h0000, outp)
        apb(1'b0, 12'h01c, 32'h0);
        `CHK("unmapped", 1'b1, err)
        $display("test regs finished");
    endtask : t_regs

    task automatic t_prog();
        logic [11:0] a;
        for (int k = 1; k <= 16; k++) begin
            a = 12'h100 + 12'(16 * (k - 1));
            wr(a, (k > 6) ? 32'h0 : (k == 6) ? 32'h2 : 32'h1);
            wr(a + 12'h004, (k == 4) ? 32'h11 : (k == 5) ? 32'h5 : 32'h0);
            wr(a + 12'h008, {16'h0, pat(k)});
            wr(12'h040 + 12'(4 * (k - 1)), 32'(k));
        end
        wr(`ETS_OFF_LAST, 32'h6);
        wr(`ETS_OFF_CTRL, 32'h1);
        wait_out(pat(1), 20, n);
        chk_rd("current", `ETS_OFF_CUR, 32'h1);
        repeat (40) @(posedge clk);
        `CHK("frozen", pat(1), outp)
        $display("test run entry finished");
    endtask : t_prog

    task automatic t_timing();
        ctl.drive(1'b1, 1'b0, 1'b0, 16'h0);
        wait_out(pat(2), 40, n);
        wait_out(pat(3), 40, d1);
        wait_out(pat(4), 40, n);
        repeat (40) @(posedge clk);
        `CHK("stall", pat(4), outp)
        ctl.drive(1'b0, 1'b1, 1'b0, 16'h0);
        wait_out(pat(1), 20, n);
        ctl.drive(1'b0, 1'b0, 1'b0, 16'h0);
        wr(`ETS_OFF_TBASE, 32'h5);
        ctl.drive(1'b1, 1'b0, 1'b0, 16'h0);
        wait_out(pat(2), 80, n);
        wait_out(pat(3), 80, d5);
        `CHK("tick_delta", 4 * CC, d5 - d1)
        wait_out(pat(4), 80, n);
        wr(12'h048, 32'h0);
        wait_out(16'h0400, 10, n);
        wr(12'h068, 32'h10);
        wait_out(16'h8000, 10, n);
        wr(12'h048, 32'h3);
        wr(12'h068, 32'hb);
        wait_out(pat(4), 10, n);
        $display("test timing finished");
    endtask : t_timing

    task automatic t_jog_done();
        ctl.drive(1'b0, 1'b0, 1'b0, 16'h0);
        ctl.pulse_jog();
        wait_out(pat(5), 20, n);
        chk_rd("timer", `ETS_OFF_TIMER, 32'h0);
        ctl.drive(1'b1, 1'b0, 1'b0, 16'h0);
        repeat (40) @(posedge clk);
        `CHK("no_event", pat(5), outp)
        ctl.drive(1'b1, 1'b0, 1'b0, 16'h0010);
        wait_out(pat(6), 60, n);
        for (n = 0; n < 100 && done !== 1'b1; n++)
            @(posedge clk);
        `CHK("done", 1'b1, done)
        if (done !== 1'b1)
            wrap_up();
        apb(1'b0, `ETS_OFF_TICKS, 32'h0);
        `CHK("done_bit", 1'b1, rd[`ETS_DONE_BIT])
        chk_rd("cur_last", `ETS_OFF_CUR, 32'h6);
        ctl.pulse_jog();
        `CHK("jog_done", pat(6), outp)
        ctl.drive(1'b1, 1'b1, 1'b0, 16'h0010);
        wait_out(pat(1), 20, n);
        repeat (40) @(posedge clk);
        `CHK("held", pat(1), outp)
        `CHK("done_clr", 1'b0, done)
        $display("test jog and done finished");
    endtask : t_jog_done

    task automatic t_restart();
        ctl.drive(1'b1, 1'b0, 1'b0, 16'h0010);
        wait_out(pat(4), 120, n);
        ctl.drive(1'b1, 1'b0, 1'b1, 16'h0010);
        ctl.pulse_jog();
        wait_out(pat(6), 100, n);
        wait_out(pat(1), 120, n);
        repeat (2) @(posedge clk);
        `CHK("auto_clr", 1'b0, done)
        ctl.drive(1'b0, 1'b0, 1'b0, 16'h0);
        wr(`ETS_OFF_CTRL, 32'h0);
        wait_out(16'h0000, 20, n);
        wr(`ETS_OFF_PRESET, 32'h3);
        chk_rd("preset_wr", `ETS_OFF_PRESET, 32'h3);
        wr(`ETS_OFF_CTRL, 32'h1);
        wait_out(pat(3), 20, n);
        chk_rd("cur_entry", `ETS_OFF_CUR, 32'h3);
        wr(`ETS_OFF_CUR, 32'h7);
        chk_rd("cur_ro", `ETS_OFF_CUR, 32'h3);
        $display("test restart finished");
    endtask : t_restart

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_prog();
        t_timing();
        t_jog_done();
        t_restart();
        wrap_up();
    end
endmodule : event_timed_step_sequencer_tb_top
